//--- verif/tb_top.sv
// Self-checking testbench for the period-match timer.
`timescale 1ns/10ps
module tb_top;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic wb_cyc_i = 1'b0;
  logic wb_stb_i = 1'b0;
  logic wb_we_i = 1'b0;
  logic [4:0] wb_adr_i = 5'h00;
  logic [3:0] wb_sel_i = 4'hf;
  logic [31:0] wb_dat_i = 32'h0;
  logic [31:0] wb_dat_o;
  logic wb_ack_o;
  logic wb_err_o;
  logic match_o;
  logic shift_clk_o;
  logic irq_o;
  int n_mismatch = 0;
  int check_count = 0;
  int cyc_n = 0;
  int mq[$];
  logic [31:0] rd;
  logic bad;
  logic [7:0] v;
  int ps, p, k, i;
  int nlist[4] = '{1, 2, 16, 5};

  period_match_timer8 period_match_timer8_inst (.clk_i(clk_i),
    .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
    .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .wb_err_o(wb_err_o), .match_o(match_o), .shift_clk_o(shift_clk_o),
    .irq_o(irq_o));

  initial begin
    forever #25 clk_i = ~clk_i;
  end

  // ======================================================================
  // Compare tasks and closing report.
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chk_rng(input int got, input int lo, input int hi);
    check_count++;
    if (got < lo || got > hi) begin
      n_mismatch++;
      $display("FAIL t=%0t got=%h exp=%h..%h", $time, got, lo, hi);
    end
  endtask

  task automatic final_report();
    $display("checks=%0d mismatches=%0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // ======================================================================
  // Bus cycles: the request is held until ack or err is sampled high.
  task automatic bus(input logic we, input logic [4:0] a,
                     input logic [7:0] d);
    int j;
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= a;
    wb_dat_i <= {24'h000000, d};
    for (j = 0; j < 20; j++) begin
      @(posedge clk_i);
      if (wb_ack_o === 1'b1 || wb_err_o === 1'b1) break;
    end
    rd = wb_dat_o;
    bad = wb_err_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    if (j == 20) begin
      n_mismatch++;
      final_report();
    end
  endtask

  task automatic rdchk(input logic [4:0] a, input logic [7:0] e);
    bus(1'b0, a, 8'h00);
    chk(rd, {24'h000000, e});
  endtask

  task automatic wait_mq(input int n, input int lim);
    int j;
    for (j = 0; j < lim && mq.size() < n; j++) @(posedge clk_i);
    if (mq.size() < n) begin
      n_mismatch++;
      final_report();
    end
  endtask

  // The match log is the reference for the prescaler and postscaler timing expectations.
  always @(posedge clk_i) begin
    cyc_n <= cyc_n + 1;
    if (match_o === 1'b1) mq.push_back(cyc_n);
    if (!rst_i) chk(shift_clk_o, match_o);
  end

  // ======================================================================
  // Main sequence.
  initial begin
    void'($urandom(42));
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    rdchk(5'h00, 8'h00);
    rdchk(5'h04, 8'hff);
    rdchk(5'h08, 8'h00);
    rdchk(5'h0c, 8'h00);
    rdchk(5'h10, 8'h00);
    bus(1'b1, 5'h08, 8'hff);
    rdchk(5'h08, 8'h7f);
    bus(1'b1, 5'h08, 8'h78);
    repeat (4) begin
      v = 8'($urandom);
      bus(1'b1, 5'h04, v);
      rdchk(5'h04, v);
      bus(1'b1, 5'h00, v);
      rdchk(5'h00, v);
    end
    bus(1'b1, 5'h00, 8'h42);
    bus(1'b1, 5'h08, 8'h78);
    rdchk(5'h00, 8'h42);
    repeat (200) @(posedge clk_i);
    rdchk(5'h00, 8'h42);
    chk_rng(mq.size(), 0, 0);
    bus(1'b0, 5'h14, 8'h00);
    chk(bad, 1'b1);
    $display("test registers done");
    // Writes more often than one divide-by-16 tick keep the count at zero.
    bus(1'b1, 5'h00, 8'h00);
    bus(1'b1, 5'h04, 8'h03);
    for (i = 0; i < 8; i++) begin
      bus(1'b1, (i < 4) ? 5'h08 : 5'h00, (i < 4) ? 8'h06 : 8'h00);
      repeat (36) @(posedge clk_i);
      rdchk(5'h00, 8'h00);
    end
    rdchk(5'h00, 8'h00);
    $display("test scaler clear done");
    for (ps = 0; ps < 4; ps++) begin
      p = (ps == 0) ? 1 : (ps == 1) ? 4 : 16;
      bus(1'b1, 5'h08, {6'h01, ps[1:0]});
      mq.delete();
      wait_mq(3, 3000);
      chk_rng(mq[2] - mq[1], 12 * p, 16 * p + 2);
    end
    $display("test prescaler done");
    bus(1'b1, 5'h08, 8'h04);
    bus(1'b1, 5'h0c, 8'h01);
    mq.delete();
    wait_mq(3, 200);
    chk(irq_o, 1'b0);
    rdchk(5'h0c, 8'h01);
    bus(1'b1, 5'h10, 8'h01);
    repeat (2) @(posedge clk_i);
    chk(irq_o, 1'b1);
    for (k = 0; k < 4; k++) begin
      if (k == 3) nlist[3] = 1 + ($urandom % 16);
      bus(1'b1, 5'h08, 8'h00);
      bus(1'b1, 5'h00, 8'h00);
      bus(1'b1, 5'h0c, 8'h01);
      rdchk(5'h0c, 8'h00);
      chk(irq_o, 1'b0);
      bus(1'b1, 5'h08, {1'b0, 4'(nlist[k] - 1), 3'h4});
      mq.delete();
      for (i = 0; i < 1000 && irq_o !== 1'b1; i++) @(posedge clk_i);
      if (irq_o !== 1'b1) begin
        n_mismatch++;
        final_report();
      end
      chk_rng(mq.size(), nlist[k], nlist[k]);
    end
    $display("test postscaler done");
    // A second reset in mid-run returns count, period and control to their reset values and drops the interrupt.
    rst_i <= 1'b1;
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    rdchk(5'h00, 8'h00);
    rdchk(5'h04, 8'hff);
    rdchk(5'h08, 8'h00);
    chk(irq_o, 1'b0);
    $display("test reset done");
    final_report();
  end
endmodule

//--- verilog/period_match_timer8.sv
// Period-match timer with Wishbone registers and masked interrupt.
`timescale 1ns/10ps
`include "period_match_timer8_params.svh"
// Behaviour
// - Count and period are 8-bit registers, readable and writable anytime.
// - When enabled, count increments once per prescaled tick of clock/4.
// - Prescaler divides by 1, 4 or 16 per control bits 1:0.
// - Control bits 6:3 pick postscale ratio field plus one.
// - Control bit 2 runs the timer; clearing it stops ticks, new matches and the postscaler.
// - Count equal to period asserts the match output.
// - A match reloads count with zero and advances the postscaler.
// - Matches raise an interrupt through the postscaler.
// - Reset clears count and sets period to all ones.
// - Count write, control write and reset clear both scalers.
// - Writing control leaves the count unchanged.
// - Match output is offered as shift clock to the serial port.
// - Control bit 7 reads zero; implemented control bits reset to zero.
module period_match_timer8 (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [4:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output logic wb_err_o,
  output logic match_o,
  output logic shift_clk_o,
  output logic irq_o
);
  logic [7:0] count_q, count_d;
  logic [7:0] period_q, period_d;
  logic [6:0] control_q, control_d;
  logic [3:0] post_q, post_d;
  logic status_q, status_d;
  logic mask_q, mask_d;
  logic match_q, match_d;
  logic shift_q, shift_d;
  logic irq_q, irq_d;
  logic ack_q, ack_d;
  logic err_q, err_d;
  logic [31:0] rdat_q, rdat_d;
  logic req, wr, lane0;
  logic hit_count, hit_period, hit_control, hit_status, hit_mask;
  logic scaler_clear, tick, run, equal, event_set;

  // ====================================================================
  // Bus decode
  always_comb begin
    req = wb_cyc_i && wb_stb_i && !ack_q && !err_q;
    // Writes commit at the edge where the master samples ack high.
    wr = wb_cyc_i && wb_stb_i && wb_we_i && ack_q;
    lane0 = wb_sel_i[0];
    hit_count = 1'b0;
    hit_period = 1'b0;
    hit_control = 1'b0;
    hit_status = 1'b0;
    hit_mask = 1'b0;
    if (wb_adr_i == `ADDR_COUNT) begin
      hit_count = 1'b1;
    end else if (wb_adr_i == `ADDR_PERIOD) begin
      hit_period = 1'b1;
    end else if (wb_adr_i == `ADDR_CONTROL) begin
      hit_control = 1'b1;
    end else if (wb_adr_i == `ADDR_IRQ_STATUS) begin
      hit_status = 1'b1;
    end else if (wb_adr_i == `ADDR_IRQ_MASK) begin
      hit_mask = 1'b1;
    end
  end

  // A write without byte lane 0 still counts as an access for the
  // scaler clear, since software touched the register.
  assign scaler_clear = wr && (hit_count || hit_control);
  assign run = control_q[`CTL_RUN];

  tick_divider u_div (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .clear_i(scaler_clear),
    .run_i(run),
    .prescale_select_i(control_q[`CTL_PRE_HI:`CTL_PRE_LO]),
    .tick_o(tick)
  );

  // ====================================================================
  // Timer core
  always_comb begin
    // Comparison runs each cycle, but a stopped timer raises no match.
    // The count stays at the period during the match cycle, so a match
    // blocks the next one; a period of zero matches every second cycle.
    equal = run && !match_q && (count_q == period_q);
    match_d = equal;
    shift_d = equal;
    count_d = count_q;
    post_d = post_q;
    event_set = 1'b0;
    if (match_q) begin
      count_d = `COUNT_RST;
    end else if (tick) begin
      count_d = count_q + 8'h01;
    end
    if (match_q && run && !scaler_clear) begin
      if (post_q == control_q[`CTL_POST_HI:`CTL_POST_LO]) begin
        post_d = 4'h0;
        event_set = 1'b1;
      end else begin
        post_d = post_q + 4'h1;
      end
    end
    if (scaler_clear) begin
      post_d = 4'h0;
    end
    if (wr && hit_count && lane0) begin
      count_d = wb_dat_i[7:0];
    end
  end

  // ====================================================================
  // Registers and interrupt
  always_comb begin
    period_d = period_q;
    control_d = control_q;
    mask_d = mask_q;
    status_d = status_q;
    if (wr && hit_period && lane0) begin
      period_d = wb_dat_i[7:0];
    end
    if (wr && hit_control && lane0) begin
      control_d = wb_dat_i[6:0] & `CTL_WMASK;
    end
    if (wr && hit_mask && lane0) begin
      mask_d = wb_dat_i[0];
    end
    if (wr && hit_status && lane0 && wb_dat_i[0]) begin
      status_d = 1'b0;
    end
    if (event_set) begin
      status_d = 1'b1;
    end
    irq_d = status_d && mask_d;
    ack_d = 1'b0;
    err_d = 1'b0;
    rdat_d = 32'h0;
    if (req) begin
      if (hit_count || hit_period || hit_control || hit_status || hit_mask) begin
        ack_d = 1'b1;
      end else begin
        err_d = 1'b1;
      end
      if (hit_count) begin
        rdat_d = {24'h0, count_q};
      end else if (hit_period) begin
        rdat_d = {24'h0, period_q};
      end else if (hit_control) begin
        rdat_d = {25'h0, control_q};
      end else if (hit_status) begin
        rdat_d = {31'h0, status_q};
      end else if (hit_mask) begin
        rdat_d = {31'h0, mask_q};
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      count_q <= `COUNT_RST;
      period_q <= `PERIOD_RST;
      control_q <= 7'(`CONTROL_RST);
      post_q <= 4'h0;
      status_q <= 1'b0;
      mask_q <= 1'b0;
      match_q <= 1'b0;
      shift_q <= 1'b0;
      irq_q <= 1'b0;
      ack_q <= 1'b0;
      err_q <= 1'b0;
      rdat_q <= 32'h0;
    end else begin
      count_q <= count_d;
      period_q <= period_d;
      control_q <= control_d;
      post_q <= post_d;
      status_q <= status_d;
      mask_q <= mask_d;
      match_q <= match_d;
      shift_q <= shift_d;
      irq_q <= irq_d;
      ack_q <= ack_d;
      err_q <= err_d;
      rdat_q <= rdat_d;
    end
  end

  assign wb_dat_o = rdat_q;
  assign wb_ack_o = ack_q;
  assign wb_err_o = err_q;
  assign match_o = match_q;
  assign shift_clk_o = shift_q;
  assign irq_o = irq_q;

  // ====================================================================
  // Checks
  property p_match_reload;
    @(posedge clk_i) disable iff (rst_i)
      match_q && !(wr && hit_count) |=> count_q == 8'h00;
  endproperty
  a_match_reload: assert property (p_match_reload)
    else $error("count not reloaded after match");

  property p_match_cause;
    @(posedge clk_i) disable iff (rst_i)
      match_q |-> $past(run) && $past(count_q) == $past(period_q);
  endproperty
  a_match_cause: assert property (p_match_cause)
    else $error("match without equality");

  property p_stopped_hold;
    @(posedge clk_i) disable iff (rst_i)
      !run && !match_q && !(wr && hit_count) |=> $stable(count_q);
  endproperty
  a_stopped_hold: assert property (p_stopped_hold)
    else $error("count moved while stopped");

  property p_ctl_keeps_count;
    @(posedge clk_i) disable iff (rst_i)
      wr && hit_control && !match_q && !tick |=> $stable(count_q);
  endproperty
  a_ctl_keeps_count: assert property (p_ctl_keeps_count)
    else $error("control write changed count");

  property p_scaler_clear;
    @(posedge clk_i) disable iff (rst_i)
      scaler_clear |=> post_q == 4'h0;
  endproperty
  a_scaler_clear: assert property (p_scaler_clear)
    else $error("postscaler not cleared");

  property p_flag_source;
    @(posedge clk_i) disable iff (rst_i)
      $rose(status_q) |-> $past(match_q) && $past(post_q) ==
        $past(control_q[`CTL_POST_HI:`CTL_POST_LO]);
  endproperty
  a_flag_source: assert property (p_flag_source)
    else $error("flag set without postscale completion");

  property p_irq_level;
    @(posedge clk_i) disable iff (rst_i)
      irq_q == (status_q && mask_q);
  endproperty
  a_irq_level: assert property (p_irq_level)
    else $error("irq not following status and mask");

  property p_bit7_zero;
    @(posedge clk_i) disable iff (rst_i)
      ack_q && $past(hit_control) |-> wb_dat_o[31:7] == 25'h0;
  endproperty
  a_bit7_zero: assert property (p_bit7_zero)
    else $error("control upper bits not zero");

  property p_shift_is_match;
    @(posedge clk_i) disable iff (rst_i)
      shift_clk_o == match_o;
  endproperty
  a_shift_is_match: assert property (p_shift_is_match)
    else $error("shift clock differs from match");

  property p_match_single;
    @(posedge clk_i) disable iff (rst_i)
      match_q |=> !match_q;
  endproperty
  a_match_single: assert property (p_match_single)
    else $error("match lasted two cycles");

  property p_post_bound;
    @(posedge clk_i) disable iff (rst_i)
      post_q <= control_q[`CTL_POST_HI:`CTL_POST_LO];
  endproperty
  a_post_bound: assert property (p_post_bound)
    else $error("postscaler beyond selected ratio");

  property p_stopped_no_event;
    @(posedge clk_i) disable iff (rst_i)
      !run |-> !event_set;
  endproperty
  a_stopped_no_event: assert property (p_stopped_no_event)
    else $error("flag event while stopped");

  property p_count_step;
    @(posedge clk_i) disable iff (rst_i)
      tick && !match_q |=> count_q == $past(count_q) + 8'h01;
  endproperty
  a_count_step: assert property (p_count_step)
    else $error("count did not step on tick");

  property p_ack_pulse;
    @(posedge clk_i) disable iff (rst_i)
      wb_ack_o |=> !wb_ack_o;
  endproperty
  a_ack_pulse: assert property (p_ack_pulse)
    else $error("ack held longer than one cycle");
endmodule

//--- verilog/period_match_timer8_params.svh
// Register map, field positions and reset values of the period-match timer.
`ifndef PERIOD_MATCH_TIMER8_PARAMS_SVH
`define PERIOD_MATCH_TIMER8_PARAMS_SVH
// ======================================================================
// Register offsets (byte addresses)
`define ADDR_COUNT 5'h00
`define ADDR_PERIOD 5'h04
`define ADDR_CONTROL 5'h08
`define ADDR_IRQ_STATUS 5'h0c
`define ADDR_IRQ_MASK 5'h10
// ======================================================================
// Control fields
`define CTL_PRE_LO 0
`define CTL_PRE_HI 1
`define CTL_RUN 2
`define CTL_POST_LO 3
`define CTL_POST_HI 6
`define CTL_WMASK 7'h7f
// ======================================================================
// Reset values and counts
`define COUNT_RST 8'h00
`define PERIOD_RST 8'hff
`define CONTROL_RST 8'h00
`define CYC_DIV 2'h3
`define PRE_DIV1 4'h0
`define PRE_DIV4 4'h3
`define PRE_DIV16 4'hf
`endif

//--- verilog/period_match_timer8_pkg.sv
// Types shared by the period-match timer files.
package period_match_timer8_pkg;
  typedef enum logic [1:0] {
    PRE_DIV1 = 2'b00,
    PRE_DIV4 = 2'b01,
    PRE_DIV16A = 2'b10,
    PRE_DIV16B = 2'b11
  } prescale_t;
endpackage

//--- verilog/tick_divider.sv
// Prescaler stage: instruction-cycle divider and selectable 1/4/16 divider.
`timescale 1ns/10ps
`include "period_match_timer8_params.svh"
module tick_divider (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic clear_i,
  input wire logic run_i,
  input wire logic [1:0] prescale_select_i,
  output logic tick_o
);
  logic [1:0] cyc_q, cyc_d;
  logic [3:0] pre_q, pre_d;
  logic [3:0] limit;
  logic cyc_en;
  period_match_timer8_pkg::prescale_t sel;

  // ====================================================================
  // Divider
  always_comb begin
    sel = period_match_timer8_pkg::prescale_t'(prescale_select_i);
    cyc_en = (cyc_q == `CYC_DIV);
    case (sel)
      period_match_timer8_pkg::PRE_DIV1: limit = `PRE_DIV1;
      period_match_timer8_pkg::PRE_DIV4: limit = `PRE_DIV4;
      default: limit = `PRE_DIV16;
    endcase
    cyc_d = cyc_q;
    pre_d = pre_q;
    tick_o = 1'b0;
    if (clear_i || !run_i) begin
      cyc_d = 2'h0;
      pre_d = 4'h0;
    end else begin
      cyc_d = cyc_q + 2'h1;
      if (cyc_en) begin
        if (pre_q >= limit) begin
          pre_d = 4'h0;
          tick_o = 1'b1;
        end else begin
          pre_d = pre_q + 4'h1;
        end
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cyc_q <= 2'h0;
      pre_q <= 4'h0;
    end else begin
      cyc_q <= cyc_d;
      pre_q <= pre_d;
    end
  end

  property p_tick_needs_run;
    @(posedge clk_i) disable iff (rst_i)
      tick_o |-> run_i && !clear_i;
  endproperty
  a_tick_needs_run: assert property (p_tick_needs_run)
    else $error("tick while stopped");

  property p_tick_spacing;
    @(posedge clk_i) disable iff (rst_i)
      tick_o |=> (!tick_o) [*3];
  endproperty
  a_tick_spacing: assert property (p_tick_spacing)
    else $error("ticks too close");
endmodule
